// ### dcc_consts.svh
// Offsets, reset values and field widths of the dual comparator control block.
// Assumes the includer works on 32-bit AHB-Lite words.
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH

// ==========================================================================
// Register byte offsets (low address byte)
// ==========================================================================
`define DCC_OFS_CMP0_MODE   8'h98
`define DCC_OFS_CMP1_MODE   8'h9c
`define DCC_OFS_CMP0_INSEL  8'ha0
`define DCC_OFS_CMP1_INSEL  8'ha4
`define DCC_OFS_CTRL        8'ha8
`define DCC_OFS_IRQ_STAT    8'hac
`define DCC_OFS_IRQ_CLR     8'hb0
`define DCC_OFS_IRQ_EN      8'hb4
`define DCC_OFS_CMP_STATE   8'hb8

// ==========================================================================
// Reset values and sizes
// ==========================================================================
`define DCC_MODE_RST        8'h02
`define DCC_INSEL_RST       8'h00
`define DCC_MODE_MASK       8'h33
`define DCC_INSEL_MASK      8'h0f
`define DCC_CHANNELS        2
`define DCC_EVENTS          4
`define DCC_SYNC_DEPTH      2
`define DCC_HTRANS_NONSEQ   2'h2
`define DCC_ADDR_LSB        2

`endif

// ### dcc_pkg.sv
// Types shared by the dual comparator control block.
// Assumes dcc_consts.svh defines the sizes used here.
`include "dcc_consts.svh"

package dcc_pkg;

	// ======================================================================
	// Register layouts
	// ======================================================================
	typedef struct packed {
		logic [1:0] unused_hi;
		logic       rise_irq_en;
		logic       fall_irq_en;
		logic [1:0] unused_lo;
		logic [1:0] response_mode;
	} dcc_mode_t;

	typedef struct packed {
		logic [3:0] unused;
		logic [1:0] pos_sel;
		logic [1:0] neg_sel;
	} dcc_insel_t;

	// Edge events of one channel
	typedef struct packed {
		logic rise;
		logic fall;
	} dcc_edge_t;

	typedef enum logic [1:0] {
		DCC_RSP_FASTEST,
		DCC_RSP_FAST,
		DCC_RSP_SLOW,
		DCC_RSP_LOW_POWER
	} dcc_resp_t;

endpackage : dcc_pkg

// ### dcc_chan.sv
// One comparator channel: raw pass-through, clock-synchronised latched
// output and edge events. Assumes raw_in comes straight from the analog
// comparator, asynchronous to hclk.
`timescale 1ns/1ps
`include "dcc_consts.svh"

module dcc_chan (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        raw_in,
	output logic             raw_out,
	output logic             latched_out,
	output dcc_pkg::dcc_edge_t edge_ev
);

	logic [`DCC_SYNC_DEPTH-1:0] sync_q;
	logic                       prev_q;

	// ======================================================================
	// Raw path, works with hclk stopped
	// ======================================================================
	assign raw_out = raw_in;

	// ======================================================================
	// Synchroniser and edge detect
	// ======================================================================
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			sync_q <= '0;
		else
			sync_q <= {sync_q[0], raw_in};
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			prev_q <= 1'b0;
		else
			prev_q <= sync_q[`DCC_SYNC_DEPTH-1];
	end

	assign latched_out  = sync_q[`DCC_SYNC_DEPTH-1];
	assign edge_ev.rise = sync_q[`DCC_SYNC_DEPTH-1] & ~prev_q;
	assign edge_ev.fall = ~sync_q[`DCC_SYNC_DEPTH-1] & prev_q;

	chk_latch_two_ff: assert property (@(posedge hclk) disable iff (!hresetn)
		##2 (latched_out == $past(raw_in, 2)))
		else $error("latched output not two cycles behind raw input");

	chk_rise_edge: assert property (@(posedge hclk) disable iff (!hresetn)
		edge_ev.rise |-> (latched_out && !$past(latched_out) && !edge_ev.fall))
		else $error("rise event without rising latched output");

	chk_fall_edge: assert property (@(posedge hclk) disable iff (!hresetn)
		($fell(latched_out)) |-> edge_ev.fall)
		else $error("falling latched output missed");

endmodule : dcc_chan

// ### dcc_top.sv
// Dual comparator control block with an AHB-Lite register slave.
// Assumes a single AHB-Lite master, word transfers only, and analog
// comparator results arriving asynchronously on cmp_result_in.
//
// Chosen here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "dcc_consts.svh"

// Contract
// - Two comparator channels behave alike, differing only in input choices and reset capability.
// - Channel zero can request a system reset when enabled; channel one cannot.
// - Each channel offers a clock-latched result and a raw unregistered result as outputs.
// - The raw result path uses no clock and keeps working while the clock is stopped.
// - Channel zero takes its positive and negative input choice from two 2-bit fields.
// - Channel one takes its positive and negative input choice from two 2-bit fields of its own.
// - The channel-one mode register has rising-edge irq enable at bit 5 and falling at bit 4.
// - Each channel has a 2-bit response mode at bits 1..0, 0 fastest, 3 lowest power.
module dcc_top (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic [1:0]  cmp_result_in,
	output logic             cmp0_raw_out,
	output logic             cmp1_raw_out,
	output logic             cmp0_latched_out,
	output logic             cmp1_latched_out,
	output logic      [1:0]  cmp0_pos_sel,
	output logic      [1:0]  cmp0_neg_sel,
	output logic      [1:0]  cmp1_pos_sel,
	output logic      [1:0]  cmp1_neg_sel,
	output logic      [1:0]  cmp0_response_mode,
	output logic      [1:0]  cmp1_response_mode,
	output logic             cmp0_reset_req,
	output logic             irq
);

	dcc_pkg::dcc_mode_t         mode_q  [`DCC_CHANNELS];
	dcc_pkg::dcc_insel_t        insel_q [`DCC_CHANNELS];
	dcc_pkg::dcc_edge_t         edge_ev [`DCC_CHANNELS];
	logic [`DCC_CHANNELS-1:0]   raw_w;
	logic [`DCC_CHANNELS-1:0]   latched_w;
	logic                       rst_en_q;
	logic                       rst_req_q;
	logic [`DCC_EVENTS-1:0]     irq_stat_q;
	logic [`DCC_EVENTS-1:0]     irq_stat_d;
	logic [`DCC_EVENTS-1:0]     irq_en_q;
	logic [`DCC_EVENTS-1:0]     irq_set;
	logic [`DCC_EVENTS-1:0]     irq_clr;
	logic [7:0]                 addr_q;
	logic                       wr_q;
	logic                       rd_q;
	logic                       rd_done_q;
	logic [31:0]                hrdata_q;
	logic [31:0]                rd_mux;
	logic                       ap_valid;
	logic                       wr_now;

	// ======================================================================
	// Channels
	// ======================================================================
	genvar gi;
	generate
		for (gi = 0; gi < `DCC_CHANNELS; gi++)
		begin : g_chan
			dcc_chan u_chan (
				.hclk        (hclk),
				.hresetn     (hresetn),
				.raw_in      (cmp_result_in[gi]),
				.raw_out     (raw_w[gi]),
				.latched_out (latched_w[gi]),
				.edge_ev     (edge_ev[gi])
			);
			// Event pair per channel, gated by the mode-register polarity enables
			assign irq_set[2*gi+1] = edge_ev[gi].rise & mode_q[gi].rise_irq_en;
			assign irq_set[2*gi]   = edge_ev[gi].fall & mode_q[gi].fall_irq_en;
		end
	endgenerate

	assign cmp0_raw_out       = raw_w[0];
	assign cmp1_raw_out       = raw_w[1];
	assign cmp0_latched_out   = latched_w[0];
	assign cmp1_latched_out   = latched_w[1];
	assign cmp0_pos_sel       = insel_q[0].pos_sel;
	assign cmp0_neg_sel       = insel_q[0].neg_sel;
	assign cmp1_pos_sel       = insel_q[1].pos_sel;
	assign cmp1_neg_sel       = insel_q[1].neg_sel;
	assign cmp0_response_mode = mode_q[0].response_mode;
	assign cmp1_response_mode = mode_q[1].response_mode;

	// ======================================================================
	// AHB-Lite slave
	// ======================================================================
	assign ap_valid  = hsel & hready & (htrans == `DCC_HTRANS_NONSEQ);
	assign hreadyout = ~(rd_q & ~rd_done_q);
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_q;
	assign wr_now    = wr_q & hready;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			addr_q <= 8'h00;
			wr_q   <= 1'b0;
			rd_q   <= 1'b0;
		end
		else if (hready)
		begin
			addr_q <= {haddr[7:`DCC_ADDR_LSB], 2'h0};
			wr_q   <= ap_valid & hwrite;
			rd_q   <= ap_valid & ~hwrite;
		end
	end

	// Reads take one wait state so a write just before is seen
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			rd_done_q <= 1'b0;
		else if (hready)
			rd_done_q <= 1'b0;
		else if (rd_q)
			rd_done_q <= 1'b1;
	end

	always_comb
	begin
		rd_mux = 32'h0000_0000;
		case (addr_q)
			`DCC_OFS_CMP0_MODE:  rd_mux[7:0] = mode_q[0] & `DCC_MODE_MASK;
			`DCC_OFS_CMP1_MODE:  rd_mux[7:0] = mode_q[1] & `DCC_MODE_MASK;
			`DCC_OFS_CMP0_INSEL: rd_mux[7:0] = insel_q[0];
			`DCC_OFS_CMP1_INSEL: rd_mux[7:0] = insel_q[1];
			`DCC_OFS_CTRL:       rd_mux[0]   = rst_en_q;
			`DCC_OFS_IRQ_STAT:   rd_mux[`DCC_EVENTS-1:0] = irq_stat_q;
			`DCC_OFS_IRQ_EN:     rd_mux[`DCC_EVENTS-1:0] = irq_en_q;
			`DCC_OFS_CMP_STATE:  rd_mux[`DCC_CHANNELS-1:0] = latched_w;
			default:             rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata_q <= 32'h0000_0000;
		else if (rd_q && !rd_done_q)
			hrdata_q <= rd_mux;
	end

	// ======================================================================
	// Configuration registers
	// ======================================================================
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mode_q[0] <= dcc_pkg::dcc_mode_t'(`DCC_MODE_RST);
			mode_q[1] <= dcc_pkg::dcc_mode_t'(`DCC_MODE_RST);
		end
		else if (wr_now)
		begin
			if (addr_q == `DCC_OFS_CMP0_MODE)
				mode_q[0] <= dcc_pkg::dcc_mode_t'(hwdata[7:0] & `DCC_MODE_MASK);
			if (addr_q == `DCC_OFS_CMP1_MODE)
				mode_q[1] <= dcc_pkg::dcc_mode_t'(hwdata[7:0] & `DCC_MODE_MASK);
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			insel_q[0] <= dcc_pkg::dcc_insel_t'(`DCC_INSEL_RST);
			insel_q[1] <= dcc_pkg::dcc_insel_t'(`DCC_INSEL_RST);
		end
		else if (wr_now)
		begin
			if (addr_q == `DCC_OFS_CMP0_INSEL)
				insel_q[0] <= dcc_pkg::dcc_insel_t'(hwdata[7:0] & `DCC_INSEL_MASK);
			if (addr_q == `DCC_OFS_CMP1_INSEL)
				insel_q[1] <= dcc_pkg::dcc_insel_t'(hwdata[7:0] & `DCC_INSEL_MASK);
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			rst_en_q <= 1'b0;
		else if (wr_now && addr_q == `DCC_OFS_CTRL)
			rst_en_q <= hwdata[0];
	end

	// ======================================================================
	// Reset request, channel zero only, active while its output is low
	// ======================================================================
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			rst_req_q <= 1'b0;
		else
			rst_req_q <= rst_en_q & ~latched_w[0];
	end

	assign cmp0_reset_req = rst_req_q;

	// ======================================================================
	// Interrupts: sticky status, write-one clear, enable mask
	// ======================================================================
	assign irq_clr = (wr_now && addr_q == `DCC_OFS_IRQ_CLR) ? hwdata[`DCC_EVENTS-1:0] : '0;

	// Set wins over a clear in the same cycle
	always_comb
	begin
		irq_stat_d = (irq_stat_q & ~irq_clr) | irq_set;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq_stat_q <= '0;
		else
			irq_stat_q <= irq_stat_d;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq_en_q <= '0;
		else if (wr_now && addr_q == `DCC_OFS_IRQ_EN)
			irq_en_q <= hwdata[`DCC_EVENTS-1:0];
	end

	assign irq = |(irq_stat_q & irq_en_q);

	// ======================================================================
	// Checks
	// ======================================================================
	chk_rise_sets_stat: assert property (@(posedge hclk) disable iff (!hresetn)
		(edge_ev[1].rise && mode_q[1].rise_irq_en) |=> irq_stat_q[3])
		else $error("enabled channel one rise did not set status");

	chk_rise0_sets_stat: assert property (@(posedge hclk) disable iff (!hresetn)
		(edge_ev[0].rise && mode_q[0].rise_irq_en) |=> irq_stat_q[1])
		else $error("enabled channel zero rise did not set status");

	chk_fall0_sets_stat: assert property (@(posedge hclk) disable iff (!hresetn)
		(edge_ev[0].fall && mode_q[0].fall_irq_en) |=> irq_stat_q[0])
		else $error("enabled channel zero fall did not set status");

	chk_clear_stat: assert property (@(posedge hclk) disable iff (!hresetn)
		(irq_clr[3] && !irq_set[3]) |=> !irq_stat_q[3])
		else $error("cleared status bit stayed set");

	chk_masked_rise: assert property (@(posedge hclk) disable iff (!hresetn)
		(edge_ev[1].rise && !mode_q[1].rise_irq_en && !irq_stat_q[3]) |=> !irq_stat_q[3])
		else $error("disabled rise edge set status");

	chk_irq_level: assert property (@(posedge hclk) disable iff (!hresetn)
		(edge_ev[0].fall && mode_q[0].fall_irq_en && irq_en_q[0]) |=> irq)
		else $error("enabled event did not raise irq");

	chk_reset_req: assert property (@(posedge hclk) disable iff (!hresetn)
		(rst_en_q && !cmp0_latched_out) |=> cmp0_reset_req)
		else $error("channel zero reset request missing");

	chk_no_reset_req: assert property (@(posedge hclk) disable iff (!hresetn)
		!rst_en_q |=> !cmp0_reset_req)
		else $error("reset request while disabled");

	chk_mode1_write: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_now && addr_q == `DCC_OFS_CMP1_MODE) |=>
		(mode_q[1].rise_irq_en == $past(hwdata[5]) && mode_q[1].fall_irq_en == $past(hwdata[4])))
		else $error("channel one edge enables not at bits 5 and 4");

	chk_resp_mode: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_now && addr_q == `DCC_OFS_CMP1_MODE) |=> (cmp1_response_mode == $past(hwdata[1:0])))
		else $error("channel one response mode not at bits 1..0");

	chk_insel0_write: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_now && addr_q == `DCC_OFS_CMP0_INSEL) |=>
		(cmp0_pos_sel == $past(hwdata[3:2]) && cmp0_neg_sel == $past(hwdata[1:0])))
		else $error("channel zero input select not updated");

	chk_insel1_write: assert property (@(posedge hclk) disable iff (!hresetn)
		(wr_now && addr_q == `DCC_OFS_CMP1_INSEL) |=>
		(cmp1_pos_sel == $past(hwdata[3:2]) && cmp1_neg_sel == $past(hwdata[1:0])))
		else $error("channel one input select not updated");

	chk_raw_pass: assert property (@(posedge hclk) disable iff (!hresetn)
		$changed(cmp_result_in[1]) |-> ##2 (cmp1_latched_out == $past(cmp1_raw_out, 2)))
		else $error("raw and latched paths disagree");

	chk_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
		(ap_valid && !hwrite) |=> !hreadyout ##1 hreadyout)
		else $error("read answer not after exactly one wait state");

endmodule : dcc_top

// ### dcc_analog_src.sv
// Model of the analog comparator results feeding the block.
// Assumes hclk is the block clock; with a delay the change lands just after an edge.
`timescale 1ns/1ps

module dcc_analog_src (
	input  wire logic       hclk,
	output logic      [1:0] cmp_result
);
	// Level of one channel after dly edges; dly 0 acts at once, even with hclk stopped
	task automatic drive(input int ch, input logic val, input int dly);
		repeat (dly) @(posedge hclk);
		cmp_result[ch] <= val;
	endtask : drive

	initial cmp_result = 2'h0;
endmodule : dcc_analog_src

// ### tb.sv
// Self-checking bench of the dual comparator control block.
// Assumes dcc_top with its AHB-Lite slave and the analog source model.
`timescale 1ns/1ps
`include "dcc_consts.svh"

module tb;
	logic        hclk = 1'b0;
	logic        clk_run = 1'b1;
	logic        hresetn = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [1:0]  cmp_result_in;
	logic        cmp0_raw_out, cmp1_raw_out, cmp0_latched_out, cmp1_latched_out;
	logic [1:0]  cmp0_pos_sel, cmp0_neg_sel, cmp1_pos_sel, cmp1_neg_sel;
	logic [1:0]  cmp0_response_mode, cmp1_response_mode;
	logic        cmp0_reset_req;
	logic        irq;
	logic        rd_pend = 1'b0;
	logic [31:0] exp_q[$];
	int          num_errors = 0;
	int          check_count = 0;
	int          seed = 74490;

	always #2 if (clk_run) hclk = ~hclk;

	dcc_analog_src src (.hclk(hclk), .cmp_result(cmp_result_in));

	dcc_top dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .cmp_result_in(cmp_result_in),
		.cmp0_raw_out(cmp0_raw_out), .cmp1_raw_out(cmp1_raw_out),
		.cmp0_latched_out(cmp0_latched_out), .cmp1_latched_out(cmp1_latched_out),
		.cmp0_pos_sel(cmp0_pos_sel), .cmp0_neg_sel(cmp0_neg_sel), .cmp1_pos_sel(cmp1_pos_sel),
		.cmp1_neg_sel(cmp1_neg_sel), .cmp0_response_mode(cmp0_response_mode),
		.cmp1_response_mode(cmp1_response_mode), .cmp0_reset_req(cmp0_reset_req), .irq(irq)
	);

	// ======================================================================
	// Reporting
	// ======================================================================
	task automatic complete_run();
		num_errors += exp_q.size();
		$display("checks %0d, mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// ======================================================================
	// AHB-Lite master
	// ======================================================================
	task automatic wait_rdy();
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1)
		begin
			num_errors++;
			complete_run();
		end
	endtask : wait_rdy

	task automatic bus(input logic [7:0] ofs, input logic wrt, input logic [31:0] d);
		@(posedge hclk);
		haddr  <= {24'h0, ofs};
		hwrite <= wrt;
		htrans <= `DCC_HTRANS_NONSEQ;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
	endtask : bus

	task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
		bus(ofs, 1'b1, d);
	endtask : wr

	task automatic rd(input logic [7:0] ofs, input logic [31:0] e);
		exp_q.push_back(e);
		bus(ofs, 1'b0, 32'h0);
	endtask : rd

	// Read data taken at the edge that ends the data phase
	always @(posedge hclk)
	begin
		if (rd_pend && hreadyout === 1'b1)
		begin
			rd_pend = 1'b0;
			if (exp_q.size() == 0)
			begin
				num_errors++;
				$display("[ERR] t=%0t got=%h exp=%h", $time, hrdata, 32'h0);
			end
			else
				chk(hrdata, exp_q.pop_front());
			chk({31'h0, hresp}, 32'h0);
		end
		if (hresetn && htrans == `DCC_HTRANS_NONSEQ && !hwrite && hreadyout === 1'b1)
			rd_pend = 1'b1;
	end

	// ======================================================================
	// Scenarios
	// ======================================================================
	initial
	begin
		logic [31:0] v;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		rd(`DCC_OFS_CMP0_MODE, 32'h2);
		rd(`DCC_OFS_CMP1_MODE, 32'h2);
		rd(`DCC_OFS_CMP0_INSEL, 32'h0);
		rd(`DCC_OFS_CMP1_INSEL, 32'h0);
		rd(`DCC_OFS_IRQ_STAT, 32'h0);
		for (int m = 0; m < 4; m++)
		begin
			v = $random(seed);
			wr(`DCC_OFS_CMP0_MODE, (v & ~32'h3) | 32'(m));
			wr(`DCC_OFS_CMP1_MODE, (v & ~32'h3) | 32'(3 - m));
			rd(`DCC_OFS_CMP0_MODE, ((v & ~32'h3) | 32'(m)) & 32'h33);
			rd(`DCC_OFS_CMP1_MODE, ((v & ~32'h3) | 32'(3 - m)) & 32'h33);
			chk(cmp0_response_mode, 32'(m));
			chk(cmp1_response_mode, 32'(3 - m));
		end
		v = $random(seed);
		wr(`DCC_OFS_CMP0_INSEL, v);
		wr(`DCC_OFS_CMP1_INSEL, ~v);
		rd(`DCC_OFS_CMP0_INSEL, v & 32'hf);
		rd(`DCC_OFS_CMP1_INSEL, ~v & 32'hf);
		chk({28'h0, cmp0_pos_sel, cmp0_neg_sel}, v & 32'hf);
		chk({28'h0, cmp1_pos_sel, cmp1_neg_sel}, ~v & 32'hf);
		// Unmapped place
		wr(8'hbc, 32'hffffffff);
		rd(8'hbc, 32'h0);
		rd(`DCC_OFS_IRQ_CLR, 32'h0);
		// Raw follows at once, latched two edges later
		src.drive(0, 1'b1, 1);
		#1 chk(cmp0_raw_out, 32'h1);
		chk(cmp0_latched_out, 32'h0);
		@(posedge hclk);
		#1 chk(cmp0_latched_out, 32'h0);
		@(posedge hclk);
		#1 chk(cmp0_latched_out, 32'h1);
		rd(`DCC_OFS_CMP_STATE, 32'h1);
		// Clock stopped: raw path keeps working
		clk_run = 1'b0;
		#10 src.drive(1, 1'b1, 0);
		#3 chk(cmp1_raw_out, 32'h1);
		chk(cmp1_latched_out, 32'h0);
		src.drive(1, 1'b0, 0);
		#3 chk(cmp1_raw_out, 32'h0);
		clk_run = 1'b1;
		src.drive(0, 1'b0, 1);
		// Each channel with one polarity enabled at a time
		wr(`DCC_OFS_IRQ_EN, 32'hf);
		rd(`DCC_OFS_IRQ_EN, 32'hf);
		for (int c = 0; c < 2; c++)
			for (int p = 0; p < 2; p++)
			begin
				wr(c ? `DCC_OFS_CMP1_MODE : `DCC_OFS_CMP0_MODE, p ? 32'h22 : 32'h12);
				wr(`DCC_OFS_IRQ_CLR, 32'hf);
				src.drive(c, 1'b1, 1);
				src.drive(c, 1'b0, 6);
				repeat (5) @(posedge hclk);
				rd(`DCC_OFS_IRQ_STAT, 32'h1 << (2 * c + p));
				#1 chk(irq, 32'h1);
				wr(`DCC_OFS_IRQ_EN, 32'h0);
				#1 chk(irq, 32'h0);
				wr(`DCC_OFS_IRQ_EN, 32'hf);
				wr(`DCC_OFS_IRQ_CLR, 32'h1 << (2 * c + p));
				rd(`DCC_OFS_IRQ_STAT, 32'h0);
				#1 chk(irq, 32'h0);
			end
		// Reset request from channel zero only
		wr(`DCC_OFS_CTRL, 32'h1);
		rd(`DCC_OFS_CTRL, 32'h1);
		repeat (2) @(posedge hclk);
		#1 chk(cmp0_reset_req, 32'h1);
		src.drive(0, 1'b1, 1);
		repeat (4) @(posedge hclk);
		#1 chk(cmp0_reset_req, 32'h0);
		src.drive(0, 1'b0, 1);
		repeat (4) @(posedge hclk);
		#1 chk(cmp0_reset_req, 32'h1);
		wr(`DCC_OFS_CTRL, 32'h0);
		repeat (2) @(posedge hclk);
		#1 chk(cmp0_reset_req, 32'h0);
		complete_run();
	end
endmodule : tb
